//--- wdrc_pkg.sv
// package of constants and types for the watchdog reset counter
package wdrc_pkg;

  // ********************
  // register map (printed offset is a word index, byte = 4 * index)
  // ********************
  localparam logic [15:0] WDRC_SERVICE_IDX   = 16'hffff;  // service location, shares reset vector
  localparam logic [15:0] WDRC_CONFIG_IDX    = 16'h0000;  // disable bit
  localparam logic [15:0] WDRC_STATUS_IDX    = 16'h0001;  // sticky event flags, write one to clear
  localparam logic [15:0] WDRC_MASK_IDX      = 16'h0002;  // interrupt mask, same layout as status
  localparam logic [15:0] WDRC_STATE_IDX     = 16'h0003;  // live counter state, read only
  localparam int unsigned WDRC_ADDR_W        = 18;        // apb byte address width

  // ********************
  // field positions and reset values
  // ********************
  localparam int unsigned WDRC_CFG_DISABLE_BIT = 0;       // config: watchdog_disable
  localparam int unsigned WDRC_EVT_TIMEOUT_BIT = 0;       // status: watchdog_reset_flag
  localparam int unsigned WDRC_EVT_SERVICE_BIT = 1;       // status: service write seen
  localparam int unsigned WDRC_EVT_W           = 2;       // number of event bits
  localparam logic        WDRC_CFG_RESET       = 1'b0;    // watchdog enabled after reset
  localparam logic [1:0]  WDRC_MASK_RESET      = 2'h0;    // all events masked after reset
  localparam logic [1:0]  WDRC_IRQ_ALLOWED     = 2'h2;    // timeout never reaches the irq line
  localparam int unsigned WDRC_STATE_PRE_LSB   = 8;       // state register: prescaler position

  // ********************
  // counter widths and timing counts in crystal cycles
  // ********************
  localparam int unsigned WDRC_PRE_W       = 13;          // prescaler_counter width
  localparam int unsigned WDRC_CNT_W       = 6;           // watchdog counter width
  localparam int unsigned WDRC_PRE_CLR_LO  = 4;           // service clears prescaler from here
  localparam int unsigned WDRC_PRE_CLR_HI  = 12;          // up to and including this bit
  localparam int unsigned WDRC_TIMEOUT_CYC = 2**18 - 2**4; // cycles from clear to reset
  localparam logic [11:0] WDRC_PRE_TICK    = 12'hfff;     // prescaler value that steps the counter
  localparam logic [5:0]  WDRC_CNT_TRIP    = 6'h3f;       // counter value in the last period
  localparam logic [7:0]  WDRC_PRE_TRIP    = 8'hff;       // prescaler bits 11:4 at trip
  localparam int unsigned WDRC_POR_CYC     = 4096;        // power-on clear delay
  localparam logic [11:0] WDRC_POR_LAST    = 12'(WDRC_POR_CYC - 1);
  localparam int unsigned WDRC_PULSE_CYC   = 32;          // reset pin low time
  localparam logic [4:0]  WDRC_PULSE_LAST  = 5'(WDRC_PULSE_CYC - 1);

  // ********************
  // types
  // ********************
  typedef struct packed {
    logic stop;      // stop mode: prescaler clock off
    logic wait_m;    // wait mode: watchdog keeps counting
    logic monitor;   // monitor mode active
    logic brk;       // break interrupt active
  } wdrc_mode_s;

  typedef enum {
    WDRC_RUN,
    WDRC_PULSE
  } wdrc_state_e;

endpackage

//--- wdrc_prescaler.sv
// 13-bit prescaler counter with full and partial clear
`timescale 1ns/1ps
`default_nettype none

module wdrc_prescaler
(
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            run,
  input  wire logic                            clr_all,
  input  wire logic                            clr_mid,
  output logic [wdrc_pkg::WDRC_PRE_W-1:0]      count
);

  // ********************
  // prescaler state
  // ********************
  logic [wdrc_pkg::WDRC_PRE_W-1:0] pre_r;    // running count
  logic [wdrc_pkg::WDRC_PRE_W-1:0] pre_nxt;  // next count

  // next value: full clear beats partial clear beats counting
  always_comb
  begin
    pre_nxt = pre_r;
    if (clr_all)
    begin
      pre_nxt = '0;
    end
    else if (clr_mid)
    begin
      // service write keeps only the low bits
      pre_nxt = {{(wdrc_pkg::WDRC_PRE_CLR_HI-wdrc_pkg::WDRC_PRE_CLR_LO+1){1'b0}},
                 pre_r[wdrc_pkg::WDRC_PRE_CLR_LO-1:0]};
    end
    else if (run)
    begin
      // free running, wraps at the top
      pre_nxt = pre_r + 13'h0001;
    end
  end

  // register only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_r <= '0;
    end
    else
    begin
      pre_r <= pre_nxt;
    end
  end

  assign count = pre_r;

endmodule

`default_nettype wire

//--- wdrc_top.sv
// watchdog reset counter with apb register access
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - six-bit counter stepped by prescaler overflow
// - unserviced counter trips after 2^18-2^4 cycles
// - any service write restarts timeout period
// - trip drives reset low 32 cycles, flag
// - service write clears counter, prescaler 12:4
// - service read returns reset vector low byte
// - power-on clears prescaler after 4096 cycles
// - internal reset clears prescaler and counter
// - reset vector fetch clears the prescaler
// - configuration disable bit blocks new trips, not a reset pulse already started
// - timeout never raises an interrupt request, only the service event can
// - monitor with high voltage disables watchdog
// - counting continues during wait mode
// - stop mode halts the prescaler clock
// - break with high reset voltage disables
module wdrc_top
(
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [wdrc_pkg::WDRC_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                       pwdata,
  output logic [31:0]                            prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic [7:0]                        reset_vector_low,
  input  wire logic                              vector_fetch,
  input  wire logic                              internal_reset,
  input  wire wdrc_pkg::wdrc_mode_s              mode,
  input  wire logic                              hv_irq_pin,
  input  wire logic                              hv_rst_pin,
  output logic                                   reset_pin_o,
  output logic                                   reset_pin_oe,
  output logic                                   wdrc_irq
);

  // ********************
  // address decode helpers
  // ********************
  // byte address of a register index
  function automatic logic [wdrc_pkg::WDRC_ADDR_W-1:0] reg_addr(input logic [15:0] idx);
    reg_addr = {idx, 2'b00};
  endfunction

  // true when the bus addresses the given register
  function automatic logic hit(input logic [wdrc_pkg::WDRC_ADDR_W-1:0] a,
                               input logic [15:0]                      idx);
    hit = (a == reg_addr(idx));
  endfunction

  // ********************
  // pin synchronisers for the high-voltage detectors
  // ********************
  logic [1:0] hv_irq_sync_r;   // two-stage sync, irq pin detector
  logic [1:0] hv_rst_sync_r;   // two-stage sync, reset pin detector
  logic [1:0] hv_irq_sync_nxt; // next sync values
  logic [1:0] hv_rst_sync_nxt; // next sync values
  logic       hv_irq_s;        // synchronised level
  logic       hv_rst_s;        // synchronised level

  // shift the pin levels in, only stage one feeds stage two
  always_comb
  begin
    hv_irq_sync_nxt = {hv_irq_sync_r[0], hv_irq_pin};
    hv_rst_sync_nxt = {hv_rst_sync_r[0], hv_rst_pin};
  end

  // register the synchronisers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hv_irq_sync_r <= 2'h0;
      hv_rst_sync_r <= 2'h0;
    end
    else
    begin
      hv_irq_sync_r <= hv_irq_sync_nxt;
      hv_rst_sync_r <= hv_rst_sync_nxt;
    end
  end

  assign hv_irq_s = hv_irq_sync_r[1];
  assign hv_rst_s = hv_rst_sync_r[1];

  // ********************
  // apb access decode
  // ********************
  logic access;      // access phase, slave always ready
  logic wr_access;   // write taken this edge
  logic rd_access;   // read taken this edge
  logic mapped;      // address names a register
  logic service_wr;  // write to the service location

  always_comb
  begin
    access     = psel & penable;
    wr_access  = access & pwrite;
    rd_access  = access & ~pwrite;
    mapped     = hit(paddr, wdrc_pkg::WDRC_SERVICE_IDX) |
                 hit(paddr, wdrc_pkg::WDRC_CONFIG_IDX)  |
                 hit(paddr, wdrc_pkg::WDRC_STATUS_IDX)  |
                 hit(paddr, wdrc_pkg::WDRC_MASK_IDX)    |
                 hit(paddr, wdrc_pkg::WDRC_STATE_IDX);
    service_wr = wr_access & hit(paddr, wdrc_pkg::WDRC_SERVICE_IDX);
  end

  // zero wait state slave, error on unmapped address
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // ********************
  // watchdog core state
  // ********************
  wdrc_pkg::wdrc_state_e                  state_r;     // run or reset pulse
  wdrc_pkg::wdrc_state_e                  state_nxt;
  logic [wdrc_pkg::WDRC_CNT_W-1:0]        cnt_r;       // watchdog counter
  logic [wdrc_pkg::WDRC_CNT_W-1:0]        cnt_nxt;
  logic [4:0]                             pulse_cnt_r; // reset pulse length
  logic [4:0]                             pulse_cnt_nxt;
  logic [11:0]                            por_cnt_r;   // power-on delay
  logic [11:0]                            por_cnt_nxt;
  logic                                   por_done_r;  // power-on clear done
  logic                                   por_done_nxt;
  logic                                   cfg_dis_r;   // watchdog_disable bit
  logic                                   cfg_dis_nxt;
  logic [wdrc_pkg::WDRC_EVT_W-1:0]        status_r;    // sticky events
  logic [wdrc_pkg::WDRC_EVT_W-1:0]        status_nxt;
  logic [wdrc_pkg::WDRC_EVT_W-1:0]        mask_r;      // interrupt mask
  logic [wdrc_pkg::WDRC_EVT_W-1:0]        mask_nxt;
  logic [31:0]                            prdata_r;    // read data
  logic [31:0]                            prdata_nxt;
  logic [wdrc_pkg::WDRC_PRE_W-1:0]        pre_count;   // prescaler_counter value
  logic                                   pre_run;     // prescaler clock running
  logic                                   pre_clr_all; // full prescaler clear
  logic                                   por_clear;   // power-on clear strobe
  logic                                   wd_disable;  // watchdog blocked
  logic                                   cnt_tick;    // prescaler overflow step
  logic                                   trip;        // timeout reached
  logic [wdrc_pkg::WDRC_EVT_W-1:0]        evt_set;     // events this cycle
  logic [wdrc_pkg::WDRC_EVT_W-1:0]        evt_clr;     // software clears

  // ********************
  // condition logic
  // ********************
  always_comb
  begin
    pre_run = ~mode.stop;
    por_clear = ~por_done_r & (por_cnt_r == wdrc_pkg::WDRC_POR_LAST);
    wd_disable = cfg_dis_r |
                 (mode.monitor & (hv_irq_s | hv_rst_s)) |
                 (mode.brk & hv_rst_s);
    cnt_tick = pre_run & (pre_count[11:0] == wdrc_pkg::WDRC_PRE_TICK);
    // trip 2^4 before the counter wraps
    trip = (state_r == wdrc_pkg::WDRC_RUN) & ~wd_disable & pre_run & ~service_wr &
           ~internal_reset & (cnt_r == wdrc_pkg::WDRC_CNT_TRIP) &
           (pre_count[11:4] == wdrc_pkg::WDRC_PRE_TRIP);
    pre_clr_all = internal_reset | vector_fetch | por_clear | trip |
                  (state_r == wdrc_pkg::WDRC_PULSE);
  end

  // ********************
  // prescaler instance
  // ********************
  // service clears bits 12 to 4
  wdrc_prescaler u_prescaler
  (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (pre_run),
    .clr_all (pre_clr_all),
    .clr_mid (service_wr),
    .count   (pre_count)
  );

  // ********************
  // next state of counter, pulse and registers
  // ********************
  always_comb
  begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    pulse_cnt_nxt = pulse_cnt_r;
    por_cnt_nxt   = por_cnt_r;
    por_done_nxt  = por_done_r;
    cfg_dis_nxt   = cfg_dis_r;
    mask_nxt      = mask_r;
    prdata_nxt    = prdata_r;
    evt_set       = '0;
    evt_clr       = '0;

    // power-on delay counter, stops after its one clear
    if (!por_done_r)
    begin
      por_cnt_nxt = por_cnt_r + 12'h001;
      if (por_clear)
      begin
        por_done_nxt = 1'b1;
      end
    end

    // watchdog counter and reset pulse
    case (state_r)
      wdrc_pkg::WDRC_RUN:
      begin
        if (internal_reset || service_wr || wd_disable)
        begin
          cnt_nxt = '0;
        end
        else if (trip)
        begin
          cnt_nxt       = '0;
          pulse_cnt_nxt = '0;
          state_nxt     = wdrc_pkg::WDRC_PULSE;
          evt_set[wdrc_pkg::WDRC_EVT_TIMEOUT_BIT] = 1'b1;
        end
        else if (cnt_tick)
        begin
          cnt_nxt = cnt_r + 6'h01;
        end
      end
      wdrc_pkg::WDRC_PULSE:
      begin
        cnt_nxt = '0;
        if (pulse_cnt_r == wdrc_pkg::WDRC_PULSE_LAST)
        begin
          state_nxt = wdrc_pkg::WDRC_RUN;
        end
        else
        begin
          pulse_cnt_nxt = pulse_cnt_r + 5'h01;
        end
      end
      default:
      begin
        state_nxt = wdrc_pkg::WDRC_RUN;
        cnt_nxt   = '0;
      end
    endcase

    // service write is reported as an event
    if (service_wr)
    begin
      evt_set[wdrc_pkg::WDRC_EVT_SERVICE_BIT] = 1'b1;
    end

    // register writes
    if (wr_access)
    begin
      if (hit(paddr, wdrc_pkg::WDRC_CONFIG_IDX))
      begin
        cfg_dis_nxt = pwdata[wdrc_pkg::WDRC_CFG_DISABLE_BIT];
      end
      if (hit(paddr, wdrc_pkg::WDRC_STATUS_IDX))
      begin
        evt_clr = pwdata[wdrc_pkg::WDRC_EVT_W-1:0];
      end
      if (hit(paddr, wdrc_pkg::WDRC_MASK_IDX))
      begin
        mask_nxt = pwdata[wdrc_pkg::WDRC_EVT_W-1:0];
      end
    end

    // sticky flags: a set in the clearing cycle wins
    status_nxt = (status_r & ~evt_clr) | evt_set;

    // read data, registered on the taking edge
    // reads touch no counter
    if (rd_access)
    begin
      prdata_nxt = 32'h0000_0000;
      if (hit(paddr, wdrc_pkg::WDRC_SERVICE_IDX))
      begin
        prdata_nxt[7:0] = reset_vector_low;
      end
      else if (hit(paddr, wdrc_pkg::WDRC_CONFIG_IDX))
      begin
        prdata_nxt[wdrc_pkg::WDRC_CFG_DISABLE_BIT] = cfg_dis_r;
      end
      else if (hit(paddr, wdrc_pkg::WDRC_STATUS_IDX))
      begin
        prdata_nxt[wdrc_pkg::WDRC_EVT_W-1:0] = status_r;
      end
      else if (hit(paddr, wdrc_pkg::WDRC_MASK_IDX))
      begin
        prdata_nxt[wdrc_pkg::WDRC_EVT_W-1:0] = mask_r;
      end
      else if (hit(paddr, wdrc_pkg::WDRC_STATE_IDX))
      begin
        prdata_nxt[wdrc_pkg::WDRC_CNT_W-1:0] = cnt_r;
        prdata_nxt[wdrc_pkg::WDRC_STATE_PRE_LSB +: wdrc_pkg::WDRC_PRE_W] = pre_count;
      end
    end
  end

  // ********************
  // core registers
  // ********************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r     <= wdrc_pkg::WDRC_RUN;
      cnt_r       <= '0;
      pulse_cnt_r <= '0;
      por_cnt_r   <= '0;
      por_done_r  <= 1'b0;
      cfg_dis_r   <= wdrc_pkg::WDRC_CFG_RESET;
      status_r    <= '0;
      mask_r      <= wdrc_pkg::WDRC_MASK_RESET;
      prdata_r    <= 32'h0000_0000;
    end
    else
    begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
      por_cnt_r   <= por_cnt_nxt;
      por_done_r  <= por_done_nxt;
      cfg_dis_r   <= cfg_dis_nxt;
      status_r    <= status_nxt;
      mask_r      <= mask_nxt;
      prdata_r    <= prdata_nxt;
    end
  end

  // ********************
  // outputs
  // ********************
  assign prdata = prdata_r;

  assign reset_pin_o  = 1'b0;
  assign reset_pin_oe = (state_r == wdrc_pkg::WDRC_PULSE);

  assign wdrc_irq = |(status_r & mask_r & wdrc_pkg::WDRC_IRQ_ALLOWED);

endmodule

`default_nettype wire

//--- wdrc_top_sva.sv
// assertion checker for the watchdog reset counter ports
`timescale 1ns/1ps
`default_nettype none

module wdrc_top_sva
(
  input wire logic                             pclk,
  input wire logic                             presetn,
  input wire logic                             psel,
  input wire logic                             penable,
  input wire logic                             pwrite,
  input wire logic [wdrc_pkg::WDRC_ADDR_W-1:0] paddr,
  input wire logic [31:0]                      pwdata,
  input wire logic [31:0]                      prdata,
  input wire logic                             pready,
  input wire logic                             pslverr,
  input wire logic [7:0]                       reset_vector_low,
  input wire logic                             reset_pin_o,
  input wire logic                             reset_pin_oe,
  input wire logic                             wdrc_irq
);
  // ********************
  // helper logic
  // ********************
  logic [5:0] pulse_cnt_r;    // cycles the pin has been driven
  logic [5:0] pulse_cnt_nxt;  // next pulse count
  logic       dis_r;          // mirror of the disable bit
  logic       dis_nxt;        // next disable mirror
  wire        take_wr = psel && penable && pready && pwrite;   // write taken
  wire        take_rd = psel && penable && pready && !pwrite;  // read taken
  wire        svc_hit = paddr == {wdrc_pkg::WDRC_SERVICE_IDX, 2'h0};
  wire        unmapped = paddr[1:0] == 2'h0 && !svc_hit && paddr[17:2] > 16'h0003;

  // next values of the helpers
  always_comb
  begin
    pulse_cnt_nxt = reset_pin_oe ? pulse_cnt_r + 6'h01 : 6'h00;
    dis_nxt = dis_r;
    // config write updates the mirror
    if (take_wr && paddr[17:2] == wdrc_pkg::WDRC_CONFIG_IDX)
      dis_nxt = pwdata[0];
  end

  // helper registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pulse_cnt_r <= 6'h00;
      dis_r <= 1'b0;
    end
    else
    begin
      pulse_cnt_r <= pulse_cnt_nxt;
      dis_r <= dis_nxt;
    end
  end

  // ********************
  // assertions
  // ********************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pulse_len_a: assert property ($fell(reset_pin_oe) |-> pulse_cnt_r == 6'h20)
    else $error("reset pulse length wrong");
  pulse_max_a: assert property (pulse_cnt_r <= 6'h20)
    else $error("reset pulse too long");
  pin_low_a: assert property (reset_pin_oe |-> !reset_pin_o)
    else $error("driven reset pin not low");
  irq_source_a: assert property ($rose(wdrc_irq) |-> $past(take_wr))
    else $error("irq rose without a register write");
  service_guard_a: assert property (take_wr && svc_hit && !reset_pin_oe
    |-> ##2 (!$rose(reset_pin_oe))[*8]) else $error("reset right after service");
  vector_read_a: assert property (take_rd && svc_hit
    |=> prdata == {24'h000000, $past(reset_vector_low)}) else $error("service read data");
  disable_block_a: assert property (dis_r && $past(dis_r) |-> !$rose(reset_pin_oe))
    else $error("reset while disabled");
  err_access_a: assert property (psel && penable && unmapped |-> pslverr)
    else $error("no error on unmapped access");
  err_data_a: assert property (take_rd && unmapped |=> prdata == 32'h00000000)
    else $error("unmapped read data not zero");
  access_ready_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");

  cover property (take_wr && svc_hit);
  cover property (take_rd && svc_hit);
  cover property ($rose(wdrc_irq));
  cover property (take_rd && unmapped);
endmodule

bind wdrc_top wdrc_top_sva u_wdrc_top_sva
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .reset_vector_low(reset_vector_low), .reset_pin_o(reset_pin_o),
  .reset_pin_oe(reset_pin_oe), .wdrc_irq(wdrc_irq)
);

`default_nettype wire

//--- wdrc_top_test.sv
// self-checking testbench for the watchdog reset counter
`timescale 1ns/1ps
`default_nettype none

module wdrc_top_test;
  // ********************
  // stimulus and state
  // ********************
  typedef struct packed {
    logic                 dis;       // config disable bit
    wdrc_pkg::wdrc_mode_s md;        // mode levels
    logic                 hvi;       // high voltage on irq pin
    logic                 hvr;       // high voltage on reset pin
    logic                 pre_runs;  // prescaler should advance
    logic                 cnt_runs;  // counter should advance
  } wdrc_row_s;
  localparam int W = 4200;           // idle cycles between samples
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, reset_pin_o, reset_pin_oe, wdrc_irq;
  logic [7:0]  rvl = 8'h00;          // reset vector low byte
  logic        vfetch = 1'b0, ireset = 1'b0, hvi = 1'b0, hvr = 1'b0;
  wdrc_pkg::wdrc_mode_s mode = 4'h0;
  logic [31:0] rd_data;              // data of the last access
  logic        rd_err;               // error of the last access
  logic [12:0] sp, p1;               // sampled prescaler
  logic [5:0]  sc, c1;               // sampled counter
  int          cyc = 0, t_take, st, t1, tw, err_total = 0, samples_checked = 0;
  // rows: disable, mode, hv irq, hv rst, prescaler runs, counter runs
  wdrc_row_s   rows [9] = '{
    '{1'b0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b1}, '{1'b0, 4'h4, 1'b0, 1'b0, 1'b1, 1'b1},
    '{1'b0, 4'h8, 1'b0, 1'b0, 1'b0, 1'b0}, '{1'b1, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0},
    '{1'b0, 4'h2, 1'b1, 1'b0, 1'b1, 1'b0}, '{1'b0, 4'h2, 1'b0, 1'b1, 1'b1, 1'b0},
    '{1'b0, 4'h1, 1'b0, 1'b1, 1'b1, 1'b0}, '{1'b0, 4'h1, 1'b1, 1'b0, 1'b1, 1'b1},
    '{1'b0, 4'h2, 1'b0, 1'b0, 1'b1, 1'b1}};

  wdrc_top u_wdrc_top
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_vector_low(rvl), .vector_fetch(vfetch), .internal_reset(ireset), .mode(mode),
    .hv_irq_pin(hvi), .hv_rst_pin(hvr), .reset_pin_o(reset_pin_o),
    .reset_pin_oe(reset_pin_oe), .wdrc_irq(wdrc_irq)
  );

  // clock and cycle count
  always #20 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  // ********************
  // tasks
  // ********************
  // one apb transfer, waits for pready, keeps data, error and taking cycle
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd_err = pslverr;
    t_take = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
    rd_data = prdata;
  endtask

  // compare and count
  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex)
    begin
      $display("unexpected %s expected %h seen %h", nm, ex, got);
      err_total++;
    end
  endtask

  // read the live counter state
  task automatic samp;
    apb(1'b0, wdrc_pkg::WDRC_STATE_IDX, 32'h0);
    sp = rd_data[20:8];
    sc = rd_data[5:0];
    st = t_take;
  endtask

  // sample again and expect free counting since p1, c1 at t1
  task automatic adv;
    samp();
    check("prescaler", 32'(13'(p1 + 13'(st - t1))), 32'(sp));
    check("counter", 32'(c1) + 32'((int'(p1[11:0]) + st - t1) / 4096), 32'(sc));
  endtask

  task automatic pulse_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watchdog against a hung run
  initial
  begin
    repeat (70000) @(posedge pclk);
    err_total++;
    give_verdict();
  end

  // ********************
  // main sequence
  // ********************
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (W) @(posedge pclk);
    // mode and disable table
    foreach (rows[i])
    begin
      @(posedge pclk);
      mode <= rows[i].md;
      hvi <= rows[i].hvi;
      hvr <= rows[i].hvr;
      apb(1'b1, wdrc_pkg::WDRC_CONFIG_IDX, {31'h0, rows[i].dis});
      apb(1'b1, wdrc_pkg::WDRC_SERVICE_IDX, 32'h0);
      repeat (4) @(posedge pclk);
      samp();
      p1 = sp;
      c1 = sc;
      t1 = st;
      repeat (W) @(posedge pclk);
      if (rows[i].cnt_runs)
        adv();
      else
      begin
        samp();
        check("prescaler", rows[i].pre_runs ? 32'(13'(p1 + 13'(st - t1))) : 32'(p1), 32'(sp));
        check("counter", 32'h0, 32'(sc));
      end
      $display("row %0d done", i);
    end
    @(posedge pclk);
    mode <= 4'h0;
    hvi <= 1'b0;
    hvr <= 1'b0;
    rvl <= 8'ha5;
    apb(1'b1, wdrc_pkg::WDRC_CONFIG_IDX, 32'h0);
    // service read gives vector byte, counters untouched
    samp();
    p1 = sp;
    c1 = sc;
    t1 = st;
    apb(1'b0, wdrc_pkg::WDRC_SERVICE_IDX, 32'h0);
    check("vector byte", 32'h000000a5, rd_data);
    adv();
    // service write keeps only prescaler bits 3:0
    apb(1'b1, wdrc_pkg::WDRC_SERVICE_IDX, 32'h0);
    tw = t_take;
    samp();
    p1 = {9'h000, 4'(p1 + 13'(tw - t1))} + 13'(st - tw - 1);
    check("prescaler partial", 32'(p1), 32'(sp));
    check("counter cleared", 32'h0, 32'(sc));
    $display("service test done");
    // vector fetch clears prescaler only, internal reset both
    repeat (8200) @(posedge pclk);
    samp();
    p1 = sp;
    c1 = sc;
    t1 = st;
    @(posedge pclk);
    vfetch <= 1'b1;
    @(posedge pclk);
    vfetch <= 1'b0;
    tw = cyc;
    samp();
    check("fetch prescaler", 32'(st - tw - 1), 32'(sp));
    check("fetch counter", 32'(c1) + 32'((int'(p1[11:0]) + tw - t1 + 1) / 4096), 32'(sc));
    @(posedge pclk);
    ireset <= 1'b1;
    @(posedge pclk);
    ireset <= 1'b0;
    tw = cyc;
    samp();
    check("ireset prescaler", 32'(st - tw - 1), 32'(sp));
    check("ireset counter", 32'h0, 32'(sc));
    $display("clear test done");
    // interrupt raise, mask, clear of the service event; timeout mask bit alone gives no irq
    apb(1'b1, wdrc_pkg::WDRC_STATUS_IDX, 32'h3);
    apb(1'b1, wdrc_pkg::WDRC_MASK_IDX, 32'h1);
    apb(1'b1, wdrc_pkg::WDRC_SERVICE_IDX, 32'h0);
    check("irq timeout mask", 32'h0, 32'(wdrc_irq));
    apb(1'b1, wdrc_pkg::WDRC_MASK_IDX, 32'h3);
    check("irq raised", 32'h1, 32'(wdrc_irq));
    apb(1'b0, wdrc_pkg::WDRC_STATUS_IDX, 32'h0);
    check("status", 32'h2, rd_data);
    apb(1'b1, wdrc_pkg::WDRC_MASK_IDX, 32'h0);
    check("irq masked", 32'h0, 32'(wdrc_irq));
    apb(1'b1, wdrc_pkg::WDRC_MASK_IDX, 32'h2);
    apb(1'b1, wdrc_pkg::WDRC_STATUS_IDX, 32'h2);
    check("irq cleared", 32'h0, 32'(wdrc_irq));
    apb(1'b0, wdrc_pkg::WDRC_STATUS_IDX, 32'h0);
    check("status cleared", 32'h0, rd_data);
    // unmapped place
    apb(1'b1, 16'h0004, 32'hffffffff);
    check("unmapped write error", 32'h1, 32'(rd_err));
    apb(1'b0, 16'h0004, 32'h0);
    check("unmapped read error", 32'h1, 32'(rd_err));
    check("unmapped data", 32'h0, rd_data);
    $display("irq and decode test done");
    // reset in mid-run, register reset values, power-on clear
    apb(1'b1, wdrc_pkg::WDRC_CONFIG_IDX, 32'h1);
    pulse_reset();
    check("reset pin", 32'h0, 32'(reset_pin_oe));
    check("irq after reset", 32'h0, 32'(wdrc_irq));
    apb(1'b0, wdrc_pkg::WDRC_CONFIG_IDX, 32'h0);
    check("config reset", 32'h0, rd_data);
    apb(1'b0, wdrc_pkg::WDRC_MASK_IDX, 32'h0);
    check("mask reset", 32'h0, rd_data);
    apb(1'b0, wdrc_pkg::WDRC_STATUS_IDX, 32'h0);
    check("status reset", 32'h0, rd_data);
    repeat (4090) @(posedge pclk);
    samp();
    check("power-on clear", 32'h5, 32'(sp));
    $display("reset test done");
    give_verdict();
  end
endmodule

`default_nettype wire
